// file: tb.sv
`timescale 1ns/1ps
module tb;
    reg        mclk = 0, sys_rst = 1, option_write = 0, shutdown_request = 0;
    reg        wakeup_event = 0, periodic_reset_event = 0;
    reg  [7:0] option_wdata = 8'h00;
    reg  [1:0] lo_zone = 2'h2, hi_zone = 2'h2;
    wire       low_outside_rearm, low_within_reset, high_outside_rearm, high_within_reset;
    wire       thermal_restart_enable, high_threshold_select, deepest_stop_mode;
    wire       restart_reset, wakeup_irq, periodic_reset;
    wire [7:0] system_test_reg;
    integer    miscompares = 0, n_checks = 0;
    initial forever #12.5 mclk = ~mclk;
    temp_model u_tm (.*);
    thermal_shutdown_restart u_dut (.*);
    task cmp(input [7:0] got, input [7:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask
    // inputs move 2 ns after the edge, outputs read there too
    task cyc(input integer n); begin repeat (n) @(posedge mclk); #2; end endtask
    task wr_opt(input [7:0] d); begin option_write = 1; option_wdata = d; cyc(1); option_write = 0; end endtask
    task shut; begin shutdown_request = 1; cyc(1); shutdown_request = 0; end endtask
    task t_refuse;
    begin
        lo_zone = 2'h0; cyc(3); cmp(system_test_reg, 8'h00);
        wr_opt(8'h08); cmp(thermal_restart_enable, 0);
        lo_zone = 2'h2; cyc(3); cmp(system_test_reg, 8'h01);
        $display("refuse done");
    end
    endtask
    task t_shut;
    begin
        wr_opt(8'h08); cmp(thermal_restart_enable, 1);
        shut; cmp(deepest_stop_mode, 1);
        wakeup_event = 1; periodic_reset_event = 1; #1 cmp({wakeup_irq, periodic_reset}, 0);
        wakeup_event = 0; periodic_reset_event = 0; lo_zone = 2'h0;
        cyc(2); cmp({restart_reset, deepest_stop_mode}, 2'h2);
        cyc(1); shut; cyc(4); cmp(deepest_stop_mode, 1);
        lo_zone = 2'h2; cyc(3); lo_zone = 2'h0; cyc(2); cmp(restart_reset, 1);
        $display("shutdown done");
    end
    endtask
    task t_sel;
    begin
        wr_opt(8'h0c); cmp(high_threshold_select, 1);
        lo_zone = 2'h2; cyc(3); shut; lo_zone = 2'h0; cyc(3); cmp(deepest_stop_mode, 1);
        hi_zone = 2'h0; cyc(2); cmp(restart_reset, 1);
        wr_opt(8'h00); cmp(thermal_restart_enable, 0);
        $display("select done");
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    // run takes about 53 cycles, so 10 us means a hang
    initial begin #10000; miscompares = miscompares + 1; print_verdict; end
    initial
    begin
        cyc(20); sys_rst = 0;
        cmp({thermal_restart_enable, high_threshold_select}, 0);
        cmp(system_test_reg, 8'h01);
        t_refuse; t_shut; t_sel; print_verdict;
    end
endmodule // tb

// file: temp_model.sv
`timescale 1ns/1ps
// comparators per threshold; zone 0 inside reset band, 1 between, 2 outside rearm band
module temp_model (input wire mclk, input wire [1:0] lo_zone, input wire [1:0] hi_zone,
    output reg low_outside_rearm, output reg low_within_reset,
    output reg high_outside_rearm, output reg high_within_reset);
    // registered so the block sees synchronized levels
    always @(posedge mclk)
    begin
        low_outside_rearm  <= lo_zone == 2'h2;
        low_within_reset   <= lo_zone == 2'h0;
        high_outside_rearm <= hi_zone == 2'h2;
        high_within_reset  <= hi_zone == 2'h0;
    end
endmodule // temp_model

// file: thermal_restart_defines.vh
`ifndef THERMAL_RESTART_DEFINES_VH
`define THERMAL_RESTART_DEFINES_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define SYSTEM_OPTION_REG_ONE_ADDR   16'h1802
`define SYSTEM_TEST_REG_ADDR         16'h180f
`define ENABLE_BIT_POS               3
`define HIGH_SELECT_BIT_POS          2
`define ARMED_FLAG_POS               0
`define RESET_VECTOR_HI_ADDR         16'hdffe
`define RESET_VECTOR_LO_ADDR         16'hdfff

// ----------------------------------------
// reset values
// ----------------------------------------
`define ENABLE_RESET_VALUE           1'b0
`define HIGH_SELECT_RESET_VALUE      1'b0
`define ARMED_FLAG_RESET_VALUE       1'b1

`endif

// file: thermal_shutdown_restart.v
`timescale 1ns/1ps
`include "thermal_restart_defines.vh"

module thermal_shutdown_restart
(
    // clock and reset
    input  wire        mclk,
    input  wire        sys_rst,
    // software writes to the option register
    input  wire        option_write,
    input  wire [7:0]  option_wdata,
    // software shutdown request at programmed temperature
    input  wire        shutdown_request,
    // comparators, low threshold
    input  wire        low_outside_rearm,
    input  wire        low_within_reset,
    // comparators, high threshold
    input  wire        high_outside_rearm,
    input  wire        high_within_reset,
    // periodic wakeup unit events
    input  wire        wakeup_event,
    input  wire        periodic_reset_event,
    // status and control out
    output reg         thermal_restart_enable,
    output reg         high_threshold_select,
    output wire [7:0]  system_test_reg,
    output reg         deepest_stop_mode,
    output reg         restart_reset,
    output wire        wakeup_irq,
    output wire        periodic_reset
);

    // ----------------------------------------
    // state encoding
    // ----------------------------------------
    localparam [2:0] st_run      = 3'b001;
    localparam [2:0] st_shutdown = 3'b010;
    localparam [2:0] st_restart  = 3'b100;

    // index of each comparator pair in the threshold arrays
    localparam       thr_low     = 0;
    localparam       thr_high    = 1;
    localparam       thr_count   = 2;

    // ----------------------------------------
    // internal signals
    // ----------------------------------------
    reg                  outside_rearm_flag;  // armed flag, set on reset
    reg  [2:0]           state;
    reg  [2:0]           next_state;
    wire [thr_count-1:0] outside_in;          // per-threshold rearm comparators
    wire [thr_count-1:0] within_in;           // per-threshold reset comparators
    wire [thr_count-1:0] outside_pick;        // rearm comparator masked by select
    wire [thr_count-1:0] within_pick;         // reset comparator masked by select
    wire [thr_count-1:0] thr_active;          // one-hot threshold choice
    wire                 sel_outside;
    wire                 sel_within;
    wire                 restart_fire;
    wire                 set_request;         // write asks for enable one
    wire                 set_allowed;         // flag permits the set
    wire                 in_shutdown;         // state decode for gating

    // ----------------------------------------
    // comparator selection
    // ----------------------------------------
    // gather both comparator pairs so one loop can mask them
    assign outside_in[thr_low]  = low_outside_rearm;
    assign outside_in[thr_high] = high_outside_rearm;
    assign within_in[thr_low]   = low_within_reset;
    assign within_in[thr_high]  = high_within_reset;

    // select bit decodes to exactly one active threshold
    assign thr_active = {high_threshold_select, ~high_threshold_select};

    // each pair passes only while chosen; the unused pair may toggle freely
    // without touching the armed flag
    genvar g;
    generate
        for (g = 0; g < thr_count; g = g + 1)
        begin : g_thr
            assign outside_pick[g] = outside_in[g] & thr_active[g];
            assign within_pick[g]  = within_in[g] & thr_active[g];
        end
    endgenerate

    // only one bit of each pick vector can be high
    assign sel_outside = |outside_pick;
    assign sel_within  = |within_pick;

    // ----------------------------------------
    // status readback
    // ----------------------------------------
    // armed flag read back, upper bits zero; software cannot write it
    assign system_test_reg = {7'h00, outside_rearm_flag};

    // ----------------------------------------
    // restart condition
    // ----------------------------------------
    // the flag is the hysteresis memory, so a unit that never left the
    // reset band cannot fire
    assign restart_fire = thermal_restart_enable & outside_rearm_flag & sel_within;

    // ----------------------------------------
    // option bits
    // ----------------------------------------
    // a set request during the reset band is dropped; clearing is always allowed
    assign set_request = option_wdata[`ENABLE_BIT_POS];
    assign set_allowed = outside_rearm_flag;

    // select is written on every write, even with a refused enable set
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            thermal_restart_enable <= `ENABLE_RESET_VALUE;
            high_threshold_select  <= `HIGH_SELECT_RESET_VALUE;
        end
        else if (option_write)
        begin
            high_threshold_select <= option_wdata[`HIGH_SELECT_BIT_POS];
            if (!set_request)
            begin
                thermal_restart_enable <= 1'b0;
            end
            else if (set_allowed)
            begin
                thermal_restart_enable <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // hysteretic armed flag
    // ----------------------------------------
    // reset band wins over rearm band, so a glitchy comparator pair can
    // never leave the flag armed while inside the reset band
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            outside_rearm_flag <= `ARMED_FLAG_RESET_VALUE;
        end
        else if (sel_within)
        begin
            outside_rearm_flag <= 1'b0;
        end
        else if (sel_outside)
        begin
            outside_rearm_flag <= 1'b1;
        end
    end

    // ----------------------------------------
    // shutdown / restart sequencer
    // ----------------------------------------
    // run to shutdown on request, shutdown to restart when armed and back in
    // band; restart lasts one cycle, so a request then is not taken
    always @*
    begin
        next_state = state;
        case (state)
            st_run:
            begin
                if (shutdown_request && thermal_restart_enable)
                begin
                    next_state = st_shutdown;
                end
            end
            st_shutdown:
            begin
                if (restart_fire)
                begin
                    next_state = st_restart;
                end
            end
            st_restart:
            begin
                next_state = st_run;
            end
            default:
            begin
                next_state = st_run;
            end
        endcase
    end

    // registered stop and reset pulse outputs
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state             <= st_run;
            deepest_stop_mode <= 1'b0;
            restart_reset     <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            deepest_stop_mode <= (next_state == st_shutdown);
            restart_reset     <= (next_state == st_restart);
        end
    end

    // ----------------------------------------
    // wakeup suppression
    // ----------------------------------------
    // registered stop level, so the gate is glitch free
    assign in_shutdown = deepest_stop_mode;

    // suppression only gates outputs; counters stay outside and keep counting
    // limitation: an event in the cycle of the request itself still passes
    assign wakeup_irq     = wakeup_event & ~in_shutdown;
    assign periodic_reset = periodic_reset_event & ~in_shutdown;

endmodule // thermal_shutdown_restart

// file: tsr_monitor.sv
`timescale 1ns/1ps
module tsr_monitor (input wire mclk, sys_rst, option_write, shutdown_request,
    low_outside_rearm, low_within_reset, high_outside_rearm, high_within_reset,
    wakeup_event, periodic_reset_event, thermal_restart_enable, high_threshold_select,
    deepest_stop_mode, restart_reset, wakeup_irq, periodic_reset,
    input wire [7:0] option_wdata, system_test_reg);
    // selected reset-band comparator
    wire sw = high_threshold_select ? high_within_reset : low_within_reset;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_stop_gates_out: assert property (deepest_stop_mode |-> !wakeup_irq && !periodic_reset)
        else $error("wakeup output during shutdown");
    a_irq_passes: assert property (!deepest_stop_mode |-> wakeup_irq == wakeup_event
        && periodic_reset == periodic_reset_event) else $error("wakeup output lost");
    a_pulse_len: assert property (restart_reset |=> !restart_reset)
        else $error("restart pulse too long");
    a_stop_enter: assert property (thermal_restart_enable && shutdown_request
        && !deepest_stop_mode && !restart_reset |=> deepest_stop_mode) else $error("no stop");
    a_stop_needs_en: assert property (!thermal_restart_enable && !deepest_stop_mode
        |=> !deepest_stop_mode) else $error("stop while disabled");
    a_enable_refused: assert property (option_write && !system_test_reg[0]
        && !thermal_restart_enable |=> !thermal_restart_enable) else $error("enable set");
    a_select_write: assert property (option_write
        |=> high_threshold_select == $past(option_wdata[2])) else $error("select wrong");
    a_restart_fire: assert property (deepest_stop_mode && thermal_restart_enable
        && system_test_reg[0] && sw |=> restart_reset && !deepest_stop_mode)
        else $error("no restart");
    a_restart_armed: assert property (restart_reset |-> $past(system_test_reg[0]))
        else $error("restart while unarmed");
    c_restart: cover property (restart_reset);
    c_gated: cover property (deepest_stop_mode && wakeup_event);
    c_refused: cover property (option_write && !system_test_reg[0]);
endmodule // tsr_monitor
bind thermal_shutdown_restart tsr_monitor u_mon (.*);
